// >>> verilog/ces_supervisor.v
// Purpose: communication error supervisor for a half-duplex serial link
// Assumes: frame strobes come from the receiver on core_clk_i; motor_stopped_i
//          and comm_option_attached_i are pins
// Notes:   settings latch on a write strobe when writing is permitted
//
// Summary of operation
// - consecutive receive errors beyond retry limit raise comm fault and stop.
// - retry limit 9999 never trips, raises minor alarm instead.
// - alarm goes to terminal coded 98 high or 198 low.
// - retry supervision only in ascii link protocol, not modbus.
// - interval 0.1 to 999.8 s: silence longer than it faults.
// - interval 9999 disables signal-loss supervision.
// - interval zero faults immediately on entering network command mode.
// - every received frame restarts loss timer, any station number.
// - loss supervision starts at first frame after entering network mode.
// - mode 0 coasts, shows fault and output at once, stays stopped.
// - mode 1 decelerates, then shows fault and output, stays stopped.
// - mode 2 decelerates without output, restarts automatically when fault clears.
// - mode 3 behaves exactly as mode 0.
// - settings writable only with group select zero or option attached.
`timescale 1ns/1ps
`default_nettype none
`include "ces_consts.vh"
module ces_supervisor #(
   parameter integer TICK_CYCLES = `CES_TICK_CYCLES,
   parameter integer NUM_TERM    = 3
) (
   input  wire                  core_clk_i,
   input  wire                  rst_i,
   input  wire                  frame_ok_i,
   input  wire                  frame_err_i,
   input  wire                  proto_modbus_i,
   input  wire                  net_mode_i,
   input  wire                  motor_stopped_i,
   input  wire                  comm_option_attached_i,
   input  wire                  fault_reset_i,
   input  wire [7:0]            user_group_read_select_i,
   input  wire                  set_wr_i,
   input  wire [15:0]           retry_limit_setting_i,
   input  wire [15:0]           loss_check_interval_i,
   input  wire [1:0]            stop_mode_on_comm_fault_i,
   input  wire [8*NUM_TERM-1:0] output_terminal_function_select_i,
   output reg                   coast_stop_o,
   output reg                   decel_stop_o,
   output reg                   comm_fault_code_o,
   output reg                   fault_out_o,
   output reg                   minor_comm_alarm_o,
   output reg  [NUM_TERM-1:0]   term_o,
   output reg                   set_wr_ok_o,
   output reg  [15:0]           err_count_o,
   output reg  [15:0]           loss_count_o
);

   // ****************************************
   // pins and settings
   // ****************************************
   // both pins are asynchronous to the core clock, hence the synchronisers
   wire stopped_s;
   wire option_s;
   ces_sync3 u_sync_stop (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .pin_i      (motor_stopped_i),
      .level_o    (stopped_s)
   );
   ces_sync3 u_sync_opt (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .pin_i      (comm_option_attached_i),
      .level_o    (option_s)
   );

   reg [15:0] retry_limit;
   reg [15:0] check_int;
   reg [1:0]  stop_mode;
   wire       wr_ok = (user_group_read_select_i == 8'h00) | option_s;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         retry_limit <= `CES_RETRY_RESET;
         check_int   <= `CES_CHECK_RESET;
         stop_mode   <= `CES_STOP_RESET;
      end else if (set_wr_i && wr_ok) begin
         retry_limit <= retry_limit_setting_i;
         check_int   <= loss_check_interval_i;
         stop_mode   <= stop_mode_on_comm_fault_i;
      end
   end

   // ****************************************
   // retry supervision
   // ****************************************
   wire frame_any = frame_ok_i | frame_err_i;
   wire retry_on  = ~proto_modbus_i;
   wire unlimited = (retry_limit == `CES_RETRY_UNLIMITED);
   reg  [15:0] err_count;
   reg         retry_trip;
   reg         alarm;
   // saturate so a long error burst cannot wrap back to a harmless count
   wire [15:0] next_err = (err_count == 16'hffff) ? err_count : err_count + 16'h1;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         err_count  <= 16'h0;
         retry_trip <= 1'b0;
         alarm      <= 1'b0;
      end else if (!retry_on) begin
         err_count  <= 16'h0;
         retry_trip <= 1'b0;
         alarm      <= 1'b0;
      end else if (frame_ok_i) begin
         err_count <= 16'h0;
         alarm     <= 1'b0;
         retry_trip <= 1'b0;
      end else if (frame_err_i) begin
         err_count <= next_err;
         if (unlimited) begin
            alarm <= 1'b1;
         end else if (next_err > retry_limit) begin
            retry_trip <= 1'b1;
         end
      end
   end

   // ****************************************
   // signal-loss supervision
   // ****************************************
   reg         net_d;
   reg         loss_armed;
   reg         loss_trip;
   reg  [15:0] loss_count;
   wire        tick;
   wire        chk_off  = (check_int == `CES_CHECK_DISABLED);
   wire        chk_zero = (check_int == `CES_CHECK_ZERO);
   wire        chk_run  = ~chk_off & ~chk_zero & (check_int <= `CES_CHECK_MAX);

   // 0.1 s step, phase restarted by frames
   ces_tick_gen #(.PERIOD(TICK_CYCLES)) u_tick (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .restart_i  (frame_any),
      .tick_o     (tick)
   );

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         net_d      <= 1'b0;
         loss_armed <= 1'b0;
         loss_trip  <= 1'b0;
         loss_count <= 16'h0;
      end else begin
         net_d <= net_mode_i;
         if (!net_mode_i) begin
            loss_armed <= 1'b0;
            loss_count <= 16'h0;
            loss_trip  <= 1'b0;
         end else if (chk_zero && !net_d) begin
            loss_trip <= 1'b1;
         end else if (chk_zero) begin
            // entry trip stands while network mode lasts, so a frame
            // cannot quietly restart a mode 2 drive
            loss_armed <= 1'b0;
            loss_count <= 16'h0;
         end else if (chk_off) begin
            loss_armed <= 1'b0;
            loss_count <= 16'h0;
            loss_trip  <= 1'b0;
         end else if (frame_any) begin
            loss_armed <= 1'b1;
            loss_count <= 16'h0;
            loss_trip  <= 1'b0;
         end else if (loss_armed && chk_run && tick) begin
            if (loss_count != 16'hffff) begin
               loss_count <= loss_count + 16'h1;
            end
            if (loss_count >= check_int) begin
               loss_trip <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // stop policy
   // ****************************************
   localparam [1:0] ST_RUN   = 2'd0;
   localparam [1:0] ST_DECEL = 2'd1;
   localparam [1:0] ST_HELD  = 2'd2;
   localparam [1:0] ST_AUTO  = 2'd3;

   // mode 1 waits for the synchronised stop pin, a few cycles after standstill
   reg  [1:0] state;
   reg  [1:0] next_state;
   wire       fault_now = retry_trip | loss_trip;
   wire       coast_mode = (stop_mode == `CES_STOP_COAST) | (stop_mode == `CES_STOP_COAST_ALT);

   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (fault_now) begin
               if (coast_mode) begin
                  next_state = ST_HELD;
               end else if (stop_mode == `CES_STOP_DECEL_AUTO) begin
                  next_state = ST_AUTO;
               end else begin
                  next_state = ST_DECEL;
               end
            end
         end
         ST_DECEL: begin
            if (stopped_s) begin
               next_state = ST_HELD;
            end
         end
         ST_HELD: begin
            if (fault_reset_i) begin
               next_state = ST_RUN;
            end
         end
         ST_AUTO: begin
            if (!fault_now) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // ****************************************
   // registered outputs
   // ****************************************
   // decoded from next_state so each stop and fault output is a flop that moves
   // together with the state register, not one cycle behind it
   wire next_held = (next_state == ST_HELD);
   wire next_slow = (next_state == ST_DECEL) | (next_state == ST_AUTO);

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state              <= ST_RUN;
         coast_stop_o       <= 1'b0;
         decel_stop_o       <= 1'b0;
         comm_fault_code_o  <= 1'b0;
         fault_out_o        <= 1'b0;
         minor_comm_alarm_o <= 1'b0;
         set_wr_ok_o        <= 1'b0;
         err_count_o        <= 16'h0;
         loss_count_o       <= 16'h0;
      end else begin
         state              <= next_state;
         coast_stop_o       <= next_held & coast_mode;
         decel_stop_o       <= next_slow | (next_held & ~coast_mode);
         comm_fault_code_o  <= next_held;
         fault_out_o        <= next_held;
         minor_comm_alarm_o <= alarm;
         set_wr_ok_o        <= wr_ok;
         err_count_o        <= err_count;
         loss_count_o       <= loss_count;
      end
   end

   // ****************************************
   // minor alarm terminals
   // ****************************************
   // unassigned terminals rest low; a 198 terminal idles high while no alarm
   integer i;
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         term_o <= {NUM_TERM{1'b0}};
      end else begin
         for (i = 0; i < NUM_TERM; i = i + 1) begin
            if (output_terminal_function_select_i[8*i +: 8] == `CES_FUNC_ALARM_POS) begin
               term_o[i] <= alarm;
            end else if (output_terminal_function_select_i[8*i +: 8] == `CES_FUNC_ALARM_NEG) begin
               term_o[i] <= ~alarm;
            end else begin
               term_o[i] <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/ces_consts.vh
// Purpose: constants for the communication error supervisor
// Assumes: 125 MHz core clock
// Notes:   settings use decimal codes as entered by the user
`ifndef CES_CONSTS_VH
`define CES_CONSTS_VH
`define CES_RETRY_UNLIMITED   16'd9999
`define CES_RETRY_RESET       16'd1
`define CES_CHECK_DISABLED    16'd9999
`define CES_CHECK_ZERO        16'd0
`define CES_CHECK_MAX         16'd9998
`define CES_CHECK_RESET       16'd0
`define CES_STOP_COAST        2'd0
`define CES_STOP_DECEL        2'd1
`define CES_STOP_DECEL_AUTO   2'd2
`define CES_STOP_COAST_ALT    2'd3
`define CES_STOP_RESET        2'd0
`define CES_FUNC_ALARM_POS    8'd98
`define CES_FUNC_ALARM_NEG    8'd198
`define CES_TICK_MS           100
`define CES_CLK_MHZ           125
`define CES_TICK_CYCLES       (`CES_TICK_MS * 1000 * `CES_CLK_MHZ)
`endif

// >>> verilog/ces_tick_gen.v
// Purpose: one-cycle pulse every 0.1 s
// Assumes: single clock domain
// Notes:   period is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
module ces_tick_gen #(
   parameter integer PERIOD = 12500000
) (
   input  wire        core_clk_i,
   input  wire        rst_i,
   input  wire        restart_i,
   output reg         tick_o
);
   reg [31:0] count;
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         count  <= 32'h0;
         tick_o <= 1'b0;
      end else if (restart_i) begin
         // phase realigned to the last frame
         count  <= 32'h0;
         tick_o <= 1'b0;
      end else if (count == PERIOD - 1) begin
         count  <= 32'h0;
         tick_o <= 1'b1;
      end else begin
         count  <= count + 32'h1;
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> verilog/ces_sync3.v
// Purpose: three-flop synchroniser for a pin input
// Assumes: input asynchronous to core_clk_i
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ces_sync3 (
   input  wire        core_clk_i,
   input  wire        rst_i,
   input  wire        pin_i,
   output reg         level_o
);
   reg s1;
   reg s2;
   reg s3;
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1      <= 1'b0;
         s2      <= 1'b0;
         s3      <= 1'b0;
         level_o <= 1'b0;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level_o <= s3;
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/ces_sup_chk_asserts.sv
// Purpose: port assertions for the comm error supervisor
// Assumes: one clock domain, async active-high reset
// Notes:   latched settings are unseen, so rules are tied to counts
`timescale 1ns/1ps
`default_nettype none
module ces_sup_chk #(
   parameter integer TICK_CYCLES = 10,
   parameter integer NUM_TERM    = 3
) (
   input wire logic                  core_clk_i,
   input wire logic                  rst_i,
   input wire logic                  frame_ok_i,
   input wire logic                  frame_err_i,
   input wire logic                  proto_modbus_i,
   input wire logic                  comm_option_attached_i,
   input wire logic                  fault_reset_i,
   input wire logic [7:0]            user_group_read_select_i,
   input wire logic                  set_wr_i,
   input wire logic [8*NUM_TERM-1:0] output_terminal_function_select_i,
   input wire logic                  coast_stop_o,
   input wire logic                  decel_stop_o,
   input wire logic                  comm_fault_code_o,
   input wire logic                  fault_out_o,
   input wire logic                  minor_comm_alarm_o,
   input wire logic [NUM_TERM-1:0]   term_o,
   input wire logic                  set_wr_ok_o,
   input wire logic [15:0]           err_count_o,
   input wire logic [15:0]           loss_count_o
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   function automatic [NUM_TERM-1:0] map_term(input [8*NUM_TERM-1:0] c, input a);
      integer k;
      for (k = 0; k < NUM_TERM; k = k + 1)
         map_term[k] = (c[8*k+:8] == 8'h62) ? a : ((c[8*k+:8] == 8'hc6) ? !a : 1'b0);
   endfunction
   // counts pass an internal register and the port flop: two edges after a strobe
   AST_ERR_CLR: assert property (
      frame_ok_i |-> ##2 err_count_o == 16'h0000) else $error("count kept after good frame");
   AST_ERR_INC: assert property (
      frame_err_i && !proto_modbus_i ##1 err_count_o != 16'hffff
      |=> err_count_o == $past(err_count_o) + 16'h0001) else $error("count not stepped");
   AST_LOSS_RST: assert property (
      frame_ok_i || frame_err_i |-> ##2 loss_count_o == 16'h0000) else $error("loss count kept");
   AST_LOSS_STEP: assert property (
      loss_count_o != $past(loss_count_o) |-> loss_count_o == 16'h0000
      || loss_count_o == $past(loss_count_o) + 16'h0001) else $error("loss count jumped");
   AST_TERM_MAP: assert property (
      $stable(minor_comm_alarm_o) && $stable(output_terminal_function_select_i) && !$past(rst_i)
      |-> term_o == map_term(output_terminal_function_select_i, minor_comm_alarm_o))
      else $error("terminal map wrong");
   AST_FAULT_IND: assert property (
      fault_out_o |-> comm_fault_code_o) else $error("fault output without code");
   AST_FAULT_STOP: assert property (
      $rose(fault_out_o) |-> coast_stop_o || $past(decel_stop_o)) else $error("fault without stop");
   AST_ONE_STOP: assert property (
      !(coast_stop_o && decel_stop_o)) else $error("coast and decel together");
   AST_WR_OK: assert property (
      user_group_read_select_i == 8'h00 |=> set_wr_ok_o) else $error("write not permitted");
   AST_WR_NO: assert property (
      (user_group_read_select_i != 8'h00 && !comm_option_attached_i)[*6] |=> !set_wr_ok_o)
      else $error("write wrongly permitted");
   cover property ($rose(coast_stop_o));
   cover property ($rose(fault_out_o) && decel_stop_o);
   cover property ($rose(minor_comm_alarm_o));
endmodule
bind ces_supervisor ces_sup_chk #(.TICK_CYCLES(TICK_CYCLES), .NUM_TERM(NUM_TERM)) chk (
   .core_clk_i, .rst_i, .frame_ok_i, .frame_err_i, .proto_modbus_i, .comm_option_attached_i,
   .fault_reset_i, .user_group_read_select_i, .set_wr_i, .output_terminal_function_select_i,
   .coast_stop_o, .decel_stop_o, .comm_fault_code_o, .fault_out_o, .minor_comm_alarm_o,
   .term_o, .set_wr_ok_o, .err_count_o, .loss_count_o);
`default_nettype wire

// >>> testbench/ces_master_model.sv
// Purpose: master computer sending frames on the link
// Assumes: frames reach the block as one-cycle strobes
// Notes:   keep-alive gaps stay below the shortest interval tested
`timescale 1ns/1ps
`default_nettype none
module ces_master_model (
   input  wire logic core_clk_i,
   input  wire logic keep_alive_i,
   output var  logic frame_ok_o,
   output var  logic frame_err_o
);
   integer seed = 32'he90e;
   initial frame_ok_o = 1'b0;
   initial frame_err_o = 1'b0;
   task automatic send(input logic bad);
      @(negedge core_clk_i);
      frame_ok_o = !bad;
      frame_err_o = bad;
      @(negedge core_clk_i);
      frame_ok_o = 1'b0;
      frame_err_o = 1'b0;
   endtask
   always begin
      repeat (5 + {$random(seed)} % 20) @(negedge core_clk_i);
      if (keep_alive_i)
         send(1'b0);
   end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Purpose: self-checking bench for the comm error supervisor
// Assumes: tick shortened to 10 cycles
// Notes:   frames come from the master model
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 0, rst = 1, ka = 0, modb = 0, net = 0, mstop = 0, opt = 0, frst = 0, wr = 0;
   logic [7:0] sel = 8'h00;
   logic [15:0] retry = 16'd1, intv = 16'd0, cnt, lcnt;
   logic [1:0] mode = 2'd0;
   logic [23:0] codes = 24'h000000;
   logic [2:0] term;
   logic fok, ferr, coast, decel, code, fout, alarm, wok;
   integer err_count = 0, num_checks = 0, seed = 32'he90e, k, r, n;
   always #4 clk = ~clk;
   ces_master_model mst (.core_clk_i(clk), .keep_alive_i(ka), .frame_ok_o(fok), .frame_err_o(ferr));
   ces_supervisor #(.TICK_CYCLES(10), .NUM_TERM(3)) dut (.core_clk_i(clk), .rst_i(rst),
      .frame_ok_i(fok), .frame_err_i(ferr), .proto_modbus_i(modb), .net_mode_i(net),
      .motor_stopped_i(mstop), .comm_option_attached_i(opt), .fault_reset_i(frst),
      .user_group_read_select_i(sel), .set_wr_i(wr), .retry_limit_setting_i(retry),
      .loss_check_interval_i(intv), .stop_mode_on_comm_fault_i(mode),
      .output_terminal_function_select_i(codes), .coast_stop_o(coast), .decel_stop_o(decel),
      .comm_fault_code_o(code), .fault_out_o(fout), .minor_comm_alarm_o(alarm), .term_o(term),
      .set_wr_ok_o(wok), .err_count_o(cnt), .loss_count_o(lcnt));
   function automatic [2:0] exp_term(input [23:0] c, input a);
      for (int i = 0; i < 3; i++)
         exp_term[i] = (c[8*i+:8] == 8'd98) ? a : ((c[8*i+:8] == 8'd198) ? !a : 1'b0);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic w(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task automatic cfg(input [15:0] r, input [15:0] i, input [1:0] m);
      @(negedge clk);
      {retry, intv, mode, wr} = {r, i, m, 1'b1};
      @(negedge clk);
      wr = 0;
   endtask
   task automatic trip;
      mst.send(1);
      mst.send(1);
      w(3);
   endtask
   // fault removed, then held state checked, then cleared
   task automatic clr(input [2:0] held);
      net = 0;
      mst.send(0);
      w(3);
      check({coast, code, fout}, held, "held state");
      @(negedge clk);
      frst = 1;
      @(negedge clk);
      frst = 0;
      mstop = 0;
      w(6);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      w(8);
      rst = 0;
      opt = 1'({$random(seed)} % 2);
      w(5);
      check(wok, 1, "write permit");
      for (k = 0; k < 2; k++) begin
         r = 1 + {$random(seed)} % 3;
         mstop = 1'({$random(seed)} % 2);
         cfg(r[15:0], 9999, (k ^ ({$random(seed)} % 2)) ? 2'd3 : 2'd0);
         repeat (r) mst.send(1);
         w(3);
         check(code, 0, "errors at limit");
         mst.send(1);
         w(3);
         check({coast, decel, code, fout}, 4'b1011, "coast trip");
         check(cnt, r[15:0] + 16'd1, "errors counted");
         clr(3'b111);
         check(cnt, 0, "count cleared");
      end
      modb = 1;
      trip;
      check(code, 0, "modbus no trip");
      modb = 0;
      clr(3'b000);
      for (k = 0; k < 3; k++)
         codes[8*k+:8] = ({$random(seed)} % 2) ? 8'd98 : 8'd198;
      cfg(9999, 9999, 0);
      n = 2 + {$random(seed)} % 4;
      repeat (n) mst.send(1);
      w(3);
      check({alarm, code}, 2'b10, "unlimited alarm");
      check(cnt, n[15:0], "errors kept counting");
      check(term, exp_term(codes, 1), "alarm terminal on");
      mst.send(0);
      w(3);
      check(term, exp_term(codes, 0), "alarm terminal off");
      cfg(1, 0, 0);
      net = 1;
      w(3);
      check(code, 1, "zero interval trip");
      clr(3'b111);
      modb = 1'({$random(seed)} % 2);
      cfg(1, 9999, 0);
      net = 1;
      w(200);
      check(code, 0, "supervision off");
      net = 0;
      cfg(1, 16'd3 + 16'({$random(seed)} % 2), 0);
      net = 1;
      w(100);
      check(code, 0, "not armed before frame");
      ka = 1;
      w(300);
      check(code, 0, "kept alive");
      ka = 0;
      w(5);
      mst.send(0);
      w(25);
      check(code, 0, "inside interval");
      check(lcnt, 2, "elapsed steps");
      w(30);
      check(code, 1, "silence trip");
      clr(3'b111);
      modb = 0;
      cfg(1, 9999, 1);
      trip;
      check({decel, code, fout}, 3'b100, "decel before stop");
      mstop = 1;
      w(8);
      check({code, fout}, 2'b11, "fault after stop");
      clr(3'b011);
      cfg(1, 9999, 2);
      trip;
      mstop = 1;
      w(8);
      check({decel, fout}, 2'b10, "decel without output");
      clr(3'b000);
      check(decel, 0, "auto restart");
      sel = 8'h01 + 8'({$random(seed)} % 255);
      opt = 0;
      w(6);
      check(wok, 0, "write locked");
      cfg(1, 9999, 0);
      trip;
      check({coast, decel, fout}, 3'b010, "refused write");
      clr(3'b000);
      opt = 1;
      w(8);
      check(wok, 1, "option unlocks");
      wrap_up;
   end
   // about twenty-eight times the expected run length
   initial begin
      #200000;
      err_count++;
      wrap_up;
   end
endmodule
`default_nettype wire
